// ==== rtl/dmcc_regs.svh ====
/*
 * Register offsets, field positions, masks and reset values of the
 * margin and comparator configuration bank.
 * Assumes inclusion by its bare name from the channel and the top.
 */
`ifndef DMCC_REGS_SVH
`define DMCC_REGS_SVH

// ----------------------------------------------------------------------
// byte addresses (i2c / spi)
// ----------------------------------------------------------------------
`define DMCC_ADDR_CH1_MARGIN_HI 8'h01
`define DMCC_ADDR_CH1_MARGIN_LO 8'h02
`define DMCC_ADDR_CH1_VOUT_CMP_CFG 8'h03
`define DMCC_ADDR_CH0_MARGIN_HI 8'h13
`define DMCC_ADDR_CH0_MARGIN_LO 8'h14
`define DMCC_ADDR_CH0_VOUT_CMP_CFG 8'h15

// ----------------------------------------------------------------------
// pmbus pages and register codes
// ----------------------------------------------------------------------
`define DMCC_PAGE_CH0 8'h03
`define DMCC_PAGE_CH1 8'h00
`define DMCC_PAGE_CFG 8'hFF
`define DMCC_CODE_MARGIN_HI 8'h25
`define DMCC_CODE_MARGIN_LO 8'h26
`define DMCC_CODE_CFG_CH0 8'hDD
`define DMCC_CODE_CFG_CH1 8'hD1

// ----------------------------------------------------------------------
// field positions and masks
// ----------------------------------------------------------------------
`define DMCC_MARGIN_MSB 15
`define DMCC_MARGIN_LSB 4
`define DMCC_MASK_MARGIN_12 16'hFFF0
`define DMCC_MASK_MARGIN_10 16'hFFC0
`define DMCC_MASK_CFG 16'h1C1F
`define DMCC_GAIN_MSB 12
`define DMCC_GAIN_LSB 10
`define DMCC_BIT_OD_EN 4
`define DMCC_BIT_ROUTE_EN 3
`define DMCC_BIT_DIVIDER 2
`define DMCC_BIT_INVERT 1
`define DMCC_BIT_CMP_EN 0
`define DMCC_RESET_VALUE 16'h0000

`endif

// ==== rtl/dmcc_pkg.sv ====
/*
 * Types shared by the configuration bank and its channel logic.
 * Assumes dmcc_regs.svh is on the include path.
 */
`default_nettype none

package dmcc_pkg;

    typedef enum logic [1:0] {REF_EXTERNAL, REF_SUPPLY, REF_INTERNAL} dmcc_ref_t;

    typedef enum logic [1:0] {RK_MARGIN_HI, RK_MARGIN_LO, RK_CFG} dmcc_kind_t;

    // host access: byte address, or pmbus page plus register code
    typedef struct packed {
        logic pmbus_sel;
        logic [7:0] addr;
        logic [7:0] page;
        logic [7:0] code;
    } dmcc_req_t;

    typedef struct packed {
        logic hit;
        dmcc_kind_t kind;
        logic ch;
    } dmcc_dec_t;

    typedef struct packed {
        logic pin_out;
        logic pin_oe;
        logic result;
        logic cmp_enable;
        logic divider_sel;
        logic [2:0] gain_code;
        dmcc_ref_t ref_sel;
        logic gain_valid;
        logic [11:0] thresh_hi;
        logic [11:0] thresh_lo;
    } dmcc_chan_out_t;

endpackage

`default_nettype wire

// ==== rtl/dmcc_chan.sv ====
/*
 * One channel: comparator result path, pin drive, gain decode and
 * threshold hand-off, all from the stored configuration.
 * Assumes the raw comparator level arrives asynchronously.
 */
`default_nettype none

`include "dmcc_regs.svh"

module dmcc_chan
    import dmcc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [15:0] i_cfg,
    input wire logic [15:0] i_margin_hi,
    input wire logic [15:0] i_margin_lo,
    input wire logic [1:0] i_thresh_mode,
    input wire logic i_cmp_raw,
    output dmcc_pkg::dmcc_chan_out_t o_chan
);
    import dmcc_pkg::*;

    logic sync1_q;
    logic sync2_q;
    logic result_d;
    logic cmp_en;
    logic route_en;
    logic od_en;

    // ------------------------------------------------------------------
    // comparator input synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end
        else
        begin
            sync1_q <= i_cmp_raw;
            sync2_q <= sync1_q;
        end
    end

    assign cmp_en = i_cfg[`DMCC_BIT_CMP_EN];
    assign route_en = i_cfg[`DMCC_BIT_ROUTE_EN];
    assign od_en = i_cfg[`DMCC_BIT_OD_EN];
    assign result_d = sync2_q ^ i_cfg[`DMCC_BIT_INVERT];

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_chan <= '0;
        end
        else
        begin
            // host has already parked current output
            o_chan.cmp_enable <= cmp_en;
            o_chan.result <= cmp_en & result_d;
            if (cmp_en && route_en && od_en)
            begin
                o_chan.pin_out <= 1'b0;
                o_chan.pin_oe <= ~result_d;
            end
            else
            begin
                // an undriven pin shows low, never a stale comparator level
                o_chan.pin_out <= cmp_en & route_en & result_d;
                o_chan.pin_oe <= cmp_en & route_en;
            end
            o_chan.divider_sel <= i_cfg[`DMCC_BIT_DIVIDER];
            o_chan.gain_code <= i_cfg[`DMCC_GAIN_MSB:`DMCC_GAIN_LSB];
            unique case (i_cfg[`DMCC_GAIN_MSB:`DMCC_GAIN_LSB])
                3'h0:
                begin
                    o_chan.ref_sel <= REF_EXTERNAL;
                    o_chan.gain_valid <= 1'b1;
                end
                3'h1:
                begin
                    o_chan.ref_sel <= REF_SUPPLY;
                    o_chan.gain_valid <= 1'b1;
                end
                3'h2, 3'h3, 3'h4, 3'h5:
                begin
                    o_chan.ref_sel <= REF_INTERNAL;
                    o_chan.gain_valid <= 1'b1;
                end
                default:
                begin
                    o_chan.ref_sel <= REF_INTERNAL;
                    o_chan.gain_valid <= 1'b0;
                end
            endcase
            if (cmp_en && (i_thresh_mode == 2'h1 || i_thresh_mode == 2'h2))
            begin
                o_chan.thresh_hi <= i_margin_hi[`DMCC_MARGIN_MSB:`DMCC_MARGIN_LSB];
                o_chan.thresh_lo <= i_margin_lo[`DMCC_MARGIN_MSB:`DMCC_MARGIN_LSB];
            end
            else
            begin
                o_chan.thresh_hi <= 12'h000;
                o_chan.thresh_lo <= 12'h000;
            end
        end
    end

endmodule

`default_nettype wire

// ==== rtl/dmcc_top.sv ====
/*
 * Margin and comparator configuration bank for a two-channel converter.
 * Assumes the serial front end has already framed each access into one
 * request on I_CLK: a byte address, or a pmbus page and register code.
 */
`default_nettype none

`include "dmcc_regs.svh"

module dmcc_top
    import dmcc_pkg::*;
#(
    parameter bit RES_12BIT = 1'b1
)
(
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire dmcc_pkg::dmcc_req_t I_REQ,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [15:0] I_WDATA,
    input wire logic [1:0] I_CMP_RAW,
    input wire logic [3:0] I_THRESH_MODE,
    output logic [15:0] O_RDATA,
    output logic O_RDATA_VALID,
    output logic O_ACK,
    output dmcc_pkg::dmcc_chan_out_t [1:0] O_CHAN
);
    import dmcc_pkg::*;

    // one mask serves both margin registers; the short part drops two more bits
    localparam logic [15:0] MARGIN_MASK =
        RES_12BIT ? `DMCC_MASK_MARGIN_12 : `DMCC_MASK_MARGIN_10;

    logic [15:0] margin_hi_q [2];
    logic [15:0] margin_lo_q [2];
    logic [15:0] cfg_q [2];
    dmcc_dec_t dec;
    logic wr_hit;
    logic rd_hit;

    // ------------------------------------------------------------------
    // address decode, shared by reads and writes
    // ------------------------------------------------------------------
    function automatic dmcc_dec_t decode(input dmcc_req_t r);
        dmcc_dec_t d;
        d = '{hit: 1'b1, kind: RK_MARGIN_HI, ch: 1'b0};
        if (!r.pmbus_sel)
        begin
            unique case (r.addr)
                `DMCC_ADDR_CH0_MARGIN_HI: d.kind = RK_MARGIN_HI;
                `DMCC_ADDR_CH1_MARGIN_HI:
                begin
                    d.kind = RK_MARGIN_HI;
                    d.ch = 1'b1;
                end
                `DMCC_ADDR_CH0_MARGIN_LO: d.kind = RK_MARGIN_LO;
                `DMCC_ADDR_CH1_MARGIN_LO:
                begin
                    d.kind = RK_MARGIN_LO;
                    d.ch = 1'b1;
                end
                `DMCC_ADDR_CH0_VOUT_CMP_CFG: d.kind = RK_CFG;
                `DMCC_ADDR_CH1_VOUT_CMP_CFG:
                begin
                    d.kind = RK_CFG;
                    d.ch = 1'b1;
                end
                default: d.hit = 1'b0;
            endcase
        end
        else if (r.page == `DMCC_PAGE_CFG)
        begin
            d.kind = RK_CFG;
            if (r.code == `DMCC_CODE_CFG_CH1)
            begin
                d.ch = 1'b1;
            end
            else if (r.code != `DMCC_CODE_CFG_CH0)
            begin
                d.hit = 1'b0;
            end
        end
        else if (r.page == `DMCC_PAGE_CH0 || r.page == `DMCC_PAGE_CH1)
        begin
            d.ch = (r.page == `DMCC_PAGE_CH1);
            if (r.code == `DMCC_CODE_MARGIN_LO)
            begin
                d.kind = RK_MARGIN_LO;
            end
            else if (r.code != `DMCC_CODE_MARGIN_HI)
            begin
                d.hit = 1'b0;
            end
        end
        else
        begin
            d.hit = 1'b0;
        end
        return d;
    endfunction

    assign dec = decode(I_REQ);
    assign wr_hit = I_WR && dec.hit;
    assign rd_hit = I_RD && dec.hit;

    // ------------------------------------------------------------------
    // read mux; unmapped targets give zero
    // ------------------------------------------------------------------
    function automatic logic [15:0] read_word(input dmcc_dec_t d);
        logic [15:0] w;
        w = 16'h0000;
        if (d.hit)
        begin
            unique case (d.kind)
                RK_MARGIN_HI: w = margin_hi_q[d.ch];
                RK_MARGIN_LO: w = margin_lo_q[d.ch];
                RK_CFG: w = cfg_q[d.ch];
                default: w = 16'h0000;
            endcase
        end
        return w;
    endfunction

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            for (int i = 0; i < 2; i++)
            begin
                margin_hi_q[i] <= `DMCC_RESET_VALUE;
                margin_lo_q[i] <= `DMCC_RESET_VALUE;
                cfg_q[i] <= `DMCC_RESET_VALUE;
            end
        end
        else if (wr_hit)
        begin
            // masking on the way in keeps the read path a plain mux
            // masked bits never stored
            unique case (dec.kind)
                RK_MARGIN_HI: margin_hi_q[dec.ch] <= I_WDATA & MARGIN_MASK;
                RK_MARGIN_LO: margin_lo_q[dec.ch] <= I_WDATA & MARGIN_MASK;
                RK_CFG: cfg_q[dec.ch] <= I_WDATA & `DMCC_MASK_CFG;
                default: cfg_q[dec.ch] <= cfg_q[dec.ch];
            endcase
        end
    end

    // ------------------------------------------------------------------
    // read and acknowledge path
    // ------------------------------------------------------------------
    // unmapped reads return zero; ack tells the front end whether it hit
    always_ff @(posedge I_CLK or negedge I_RST_N)
    begin
        if (!I_RST_N)
        begin
            O_RDATA <= 16'h0000;
            O_RDATA_VALID <= 1'b0;
            O_ACK <= 1'b0;
        end
        else
        begin
            O_RDATA_VALID <= I_RD;
            // ack only mapped targets so the front end can refuse the rest
            O_ACK <= wr_hit || rd_hit;
            // a read in a write cycle returns the old word
            if (I_RD)
            begin
                O_RDATA <= read_word(dec);
            end
        end
    end

    // ------------------------------------------------------------------
    // channel logic
    // ------------------------------------------------------------------
    // channels share nothing but clock and reset, so one loop builds both
    for (genvar g = 0; g < 2; g++)
    begin : g_chan
        dmcc_chan u_chan (
            .i_clk(I_CLK),
            .i_rst_n(I_RST_N),
            .i_cfg(cfg_q[g]),
            .i_margin_hi(margin_hi_q[g]),
            .i_margin_lo(margin_lo_q[g]),
            .i_thresh_mode(I_THRESH_MODE[2*g+1 -: 2]),
            .i_cmp_raw(I_CMP_RAW[g]),
            .o_chan(O_CHAN[g])
        );
    end

endmodule

`default_nettype wire

// ==== testbench/dmcc_properties.sv ====
/*
 * Port checker for the margin and comparator bank.
 * Assumes one clock and an asynchronous active-low reset.
 */
`default_nettype none

module dmcc_properties
    import dmcc_pkg::*;
(
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire dmcc_pkg::dmcc_req_t I_REQ,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [15:0] O_RDATA,
    input wire logic O_RDATA_VALID,
    input wire logic O_ACK,
    input wire dmcc_pkg::dmcc_chan_out_t [1:0] O_CHAN
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);
    wire logic rd_a = I_RD && !I_REQ.pmbus_sel;
    wire logic wr_a = I_WR && !I_REQ.pmbus_sel;

    // ------------------------------------------------------------------
    // host access
    // ------------------------------------------------------------------
    property p_rd_valid; I_RD |=> O_RDATA_VALID; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read not answered");
    property p_unmapped; rd_a && I_REQ.addr == 8'h00 |=> !O_ACK && O_RDATA == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_lo_pad; rd_a && I_REQ.addr == 8'h14 |=> O_RDATA[3:0] == 4'h0; endproperty
    a_lo_pad: assert property (p_lo_pad) else $error("margin pad bits");
    property p_cfg_pad; rd_a && I_REQ.addr == 8'h15 |=> (O_RDATA & 16'hE3E0) == 16'h0000;
    endproperty
    a_cfg_pad: assert property (p_cfg_pad) else $error("config pad bits");
    property p_wr_ack; wr_a && I_REQ.addr == 8'h13 |=> O_ACK; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write not acked");

    // ------------------------------------------------------------------
    // channel outputs
    // ------------------------------------------------------------------
    property p_oe_en; O_CHAN[0].pin_oe |-> O_CHAN[0].cmp_enable; endproperty
    a_oe_en: assert property (p_oe_en) else $error("pin driven outside cmp");
    property p_res_off; !O_CHAN[1].cmp_enable |-> !O_CHAN[1].result; endproperty
    a_res_off: assert property (p_res_off) else $error("result while off");
    property p_pin_res; O_CHAN[0].pin_oe && O_CHAN[0].pin_out |-> O_CHAN[0].result;
    endproperty
    a_pin_res: assert property (p_pin_res) else $error("pin level");
    // reset leaves gain_valid low until the first decode edge
    property p_gain_ok;
        $past(I_RST_N) |-> O_CHAN[0].gain_valid == (O_CHAN[0].gain_code <= 3'h5);
    endproperty
    a_gain_ok: assert property (p_gain_ok) else $error("gain validity");
    property p_thr; !O_CHAN[0].cmp_enable |-> O_CHAN[0].thresh_hi == 12'h000; endproperty
    a_thr: assert property (p_thr) else $error("threshold while off");

    c_write: cover property (I_WR ##1 O_ACK);
    c_pin: cover property (O_CHAN[0].pin_oe && !O_CHAN[0].pin_out);
    c_bad_gain: cover property (!O_CHAN[0].gain_valid && O_CHAN[0].ref_sel == REF_INTERNAL);
endmodule

bind dmcc_top dmcc_properties u_props (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REQ(I_REQ),
    .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_RDATA_VALID(O_RDATA_VALID),
    .O_ACK(O_ACK), .O_CHAN(O_CHAN));

`default_nettype wire

// ==== testbench/dmcc_host_model.sv ====
/*
 * Host controller model: one framed access per call.
 * Assumes the bank answers one clock after the strobe.
 */
`default_nettype none

module dmcc_host_model
    import dmcc_pkg::*;
(
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    input wire logic i_ack,
    output dmcc_pkg::dmcc_req_t o_req,
    output logic o_wr,
    output logic o_rd,
    output logic [15:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        o_req = '0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 16'h0000;
    end

    // words go whole, codes already left-aligned
    task automatic xfer(input logic w, input dmcc_req_t t, input logic [15:0] d,
                        output logic [15:0] q, output logic a);
        @(negedge i_clk);
        o_req = t;
        o_wr = w;
        o_rd = !w;
        o_wdata = d;
        @(negedge i_clk);
        q = i_rdata;
        a = i_ack;
        o_wr = 1'b0;
        o_rd = 1'b0;
        // released lines flip so stale values never look valid
        o_req = ~t;
        o_wdata = ~d;
    endtask
endmodule

`default_nettype wire

// ==== testbench/tb.sv ====
/*
 * Self-checking bench for the margin and comparator bank.
 * Assumes the host model and the bound checker are compiled.
 */
`default_nettype none

module tb
    import dmcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk;
    logic rst_n;
    logic [1:0] cmp_raw;
    logic [3:0] thr_mode;
    dmcc_req_t req;
    logic wr;
    logic rd;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic [15:0] rdata10;
    logic rvalid;
    logic ack;
    dmcc_chan_out_t [1:0] chan;
    int err_count;
    int samples_checked;

    dmcc_top #(.RES_12BIT(1'b1)) uut (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ(req), .I_WR(wr),
        .I_RD(rd), .I_WDATA(wdata), .I_CMP_RAW(cmp_raw), .I_THRESH_MODE(thr_mode),
        .O_RDATA(rdata), .O_RDATA_VALID(rvalid), .O_ACK(ack), .O_CHAN(chan));
    // ten-bit layout sees the same accesses; only its read data is judged
    dmcc_top #(.RES_12BIT(1'b0)) uut_short (.I_CLK(clk), .I_RST_N(rst_n), .I_REQ(req),
        .I_WR(wr), .I_RD(rd), .I_WDATA(wdata), .I_CMP_RAW(cmp_raw),
        .I_THRESH_MODE(thr_mode), .O_RDATA(rdata10), .O_RDATA_VALID(), .O_ACK(),
        .O_CHAN());
    dmcc_host_model u_host (.i_clk(clk), .i_rdata(rdata), .i_ack(ack), .o_req(req),
        .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test;
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    function automatic dmcc_req_t ad(input logic [7:0] a);
        return '{1'b0, a, 8'h00, 8'h00};
    endfunction

    function automatic dmcc_req_t pm(input logic [7:0] p, input logic [7:0] c);
        return '{1'b1, 8'h00, p, c};
    endfunction

    task automatic wr_reg(input dmcc_req_t t, input logic [15:0] d);
        logic [15:0] q;
        logic a;
        u_host.xfer(1'b1, t, d, q, a);
    endtask

    task automatic rd_chk(input dmcc_req_t t, input logic [15:0] e, input logic ea);
        logic [15:0] q;
        logic a;
        u_host.xfer(1'b0, t, 16'h0000, q, a);
        chk("rdata", q, e);
        chk("ack", {15'h0000, a}, {15'h0000, ea});
        chk("rvalid", {15'h0000, rvalid}, 16'h0001);
    endtask

    task automatic t_map;
        logic [7:0] addrs [6] = '{8'h01, 8'h02, 8'h03, 8'h13, 8'h14, 8'h15};
        foreach (addrs[i]) rd_chk(ad(addrs[i]), 16'h0000, 1'b1);
        wr_reg(ad(8'h13), 16'hFFFF);
        rd_chk(ad(8'h13), 16'hFFF0, 1'b1);
        wr_reg(ad(8'h01), 16'hA5A5);
        rd_chk(pm(8'h00, 8'h25), 16'hA5A0, 1'b1);
        wr_reg(pm(8'h03, 8'h26), 16'h123F);
        rd_chk(ad(8'h14), 16'h1230, 1'b1);
        wr_reg(pm(8'h00, 8'h26), 16'hFEDC);
        rd_chk(ad(8'h02), 16'hFED0, 1'b1);
        wr_reg(pm(8'hFF, 8'hDD), 16'hFFFF);
        rd_chk(ad(8'h15), 16'h1C1F, 1'b1);
        wr_reg(pm(8'hFF, 8'hD1), 16'h5555);
        rd_chk(ad(8'h03), 16'h1415, 1'b1);
        wr_reg(ad(8'h00), 16'hFFFF);
        rd_chk(ad(8'h00), 16'h0000, 1'b0);
        wr_reg(ad(8'h03), 16'h0000);
    endtask

    task automatic t_gain;
        dmcc_ref_t er;
        for (int g = 0; g < 8; g++)
        begin
            wr_reg(ad(8'h15), 16'(g) << 10);
            repeat (2) @(negedge clk);
            er = (g == 0) ? REF_EXTERNAL : (g == 1) ? REF_SUPPLY : REF_INTERNAL;
            chk("gain", 16'(chan[0].gain_code), 16'(g));
            chk("ref", 16'(chan[0].ref_sel), 16'(er));
            chk("gain_ok", 16'(chan[0].gain_valid), 16'(g < 6));
        end
    endtask

    task automatic t_cmp;
        logic [15:0] cfgs [7] = '{16'h0001, 16'h0009, 16'h000B, 16'h0019, 16'h0019,
                                  16'h0018, 16'h0005};
        logic raws [7] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [15:0] c;
        logic res;
        // current output assumed parked before enabling
        for (int g = 0; g < 2; g++)
        begin
            foreach (cfgs[i])
            begin
                c = cfgs[i];
                @(negedge clk);
                cmp_raw[g] = raws[i];
                wr_reg(ad(g ? 8'h03 : 8'h15), c);
                repeat (4) @(negedge clk);
                res = c[0] & (raws[i] ^ c[1]);
                chk("result", 16'(chan[g].result), 16'(res));
                chk("cmp_en", 16'(chan[g].cmp_enable), 16'(c[0]));
                chk("divider", 16'(chan[g].divider_sel), 16'(c[2]));
                chk("oe", 16'(chan[g].pin_oe), 16'(c[0] & c[3] & (!c[4] | !res)));
                chk("out", 16'(chan[g].pin_out), 16'(c[0] & c[3] & !c[4] & res));
            end
        end
    endtask

    task automatic t_thresh;
        logic win;
        wr_reg(ad(8'h13), 16'hABCD);
        wr_reg(ad(8'h14), 16'h1234);
        wr_reg(ad(8'h15), 16'h0001);
        wr_reg(ad(8'h03), 16'h0001);
        for (int m = 0; m < 4; m++)
        begin
            @(negedge clk);
            thr_mode = {2'(m), 2'(m)};
            win = (m == 1 || m == 2);
            repeat (2) @(negedge clk);
            chk("thr_hi", 16'(chan[0].thresh_hi), win ? 16'h0ABC : 16'h0000);
            chk("thr_lo", 16'(chan[0].thresh_lo), win ? 16'h0123 : 16'h0000);
            chk("thr_hi1", 16'(chan[1].thresh_hi), win ? 16'h0A5A : 16'h0000);
            chk("thr_lo1", 16'(chan[1].thresh_lo), win ? 16'h0FED : 16'h0000);
        end
    endtask

    task automatic t_short;
        logic [15:0] q;
        logic a;
        wr_reg(ad(8'h14), 16'hFFFF);
        u_host.xfer(1'b0, ad(8'h14), 16'h0000, q, a);
        chk("short_lo", rdata10, 16'hFFC0);
        chk("full_lo", q, 16'hFFF0);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        cmp_raw = 2'b00;
        thr_mode = 4'h0;
        err_count = 0;
        samples_checked = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_map;
        t_gain;
        t_cmp;
        t_thresh;
        t_short;
        finish_test;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test;
    end
endmodule

`default_nettype wire
